// ===== hw/sico_top.sv
// Purpose: input configuration, polling and supply over-voltage handling
// Assumes: SPI decoding lives outside; it reports reads of the interrupt status
// Notes:   open-drain interrupt pin driven low while int_oe_out is high
//
// Contract
// - over-voltage entry turns off every wetting source and sink, halts monitoring.
// - over-voltage entry pulls interrupt pin low and sets event flag.
// - live over-voltage status reads 1 while over-voltage is present.
// - other-interrupt flag is reported in every SPI frame during over-voltage.
// - chip-select rise releases pin and clears status, only if status was read.
// - during over-voltage SPI works and all registers and switch status stay.
// - over-voltage stays until supply below threshold minus hysteresis; no repeat interrupt.
// - over-voltage exit pulls pin low, sets event flag, clears live status.
// - after recovery polling resumes from lowest enabled input with current settings.
// - first poll cycle after recovery raises switch change, becomes the baseline.
// - open or closed state of inputs 0 to 23 is reported.
// - thresholds shared by groups of four, wetting currents by listed pairs.
// - inputs 10 to 23 always use a current source.
// - inputs 0 to 9 use a sink when select bit is 1, else source.
// - after reset inputs 0 to 9 default to current source.
// - enable bit 0 turns input's currents off and stops its monitoring.
// - reset clears every input enable bit.
// - run bit 1 activates wetting currents and starts monitoring.
// - configuration is read-only while monitoring runs.
module sico_top
  import sico_pkg::*;
#(
  parameter int POLL_CYC = `SICO_POLL_STEP_CYC
) (
  input  wire logic                               core_clk_in,
  input  wire logic                               rst_b_in,
  input  wire logic                               over_cmp_in,
  input  wire logic                               cs_b_in,
  input  wire logic                               sclk_in,
  input  wire logic                               int_stat_read_in,
  input  wire logic                               run_in,
  input  wire logic                               cfg_load_in,
  input  wire sico_cfg_type                       cfg_in,
  input  wire logic [`SICO_N_IN-1:0]              switch_input_pin_in,
  output logic [`SICO_N_IN-1:0]                   switch_status_out,
  output logic                                    overvoltage_live_status_out,
  output logic                                    overvoltage_event_flag_out,
  output logic                                    switch_change_interrupt_out,
  output logic                                    other_interrupt_spi_flag_out,
  output logic                                    int_b_out,
  output logic                                    int_oe_out,
  output logic [`SICO_N_IN-1:0]                   src_en_out,
  output logic [`SICO_N_IN-1:0]                   sink_en_out,
  output logic [`SICO_N_IN*`SICO_THR_W-1:0]       comparator_threshold_group_out,
  output logic [`SICO_N_IN*`SICO_WC_W-1:0]        wetting_current_setting_out
);

  // ==========================================================================
  // functions

  // shared wetting current slot of an input
  function automatic logic [3:0] wc_slot(input int i);
    logic [3:0] s;
    s = 4'h0;
    unique case (i)
      0, 1:   s = 4'h0;
      2, 3:   s = 4'h1;
      4:      s = 4'h2;
      5:      s = 4'h3;
      6, 7:   s = 4'h4;
      8, 9:   s = 4'h5;
      10:     s = 4'h6;
      11:     s = 4'h7;
      12, 13: s = 4'h8;
      14, 15: s = 4'h9;
      16, 17: s = 4'hA;
      18, 19: s = 4'hB;
      20, 21: s = 4'hC;
      22:     s = 4'hD;
      default: s = 4'hE;
    endcase
    return s;
  endfunction

  // lowest enabled input, zero when none is enabled
  function automatic logic [`SICO_IDX_W-1:0] first_en(input logic [`SICO_N_IN-1:0] en);
    logic [`SICO_IDX_W-1:0] r;
    r = '0;
    for (int i = `SICO_N_IN - 1; i >= 0; i--) begin
      if (en[i]) begin
        r = `SICO_IDX_W'(i);
      end
    end
    return r;
  endfunction

  // next enabled input above idx; msb says one was found
  function automatic logic [`SICO_IDX_W:0] next_en(input logic [`SICO_N_IN-1:0] en,
                                                   input logic [`SICO_IDX_W-1:0] idx);
    logic [`SICO_IDX_W:0] r;
    r = '0;
    for (int i = `SICO_N_IN - 1; i >= 0; i--) begin
      if (en[i] && (i > int'(idx))) begin
        r = {1'b1, `SICO_IDX_W'(i)};
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // state

  sico_state_type st_ff;
  sico_state_type nxt_st;

  logic                   over_enter;
  logic                   over_leave;
  logic                   cs_rise;
  logic                   cs_fall;
  logic                   ck_first;
  logic                   clr_stat;
  logic                   mon_on;
  logic                   tick;
  logic                   cyc_end;
  logic [`SICO_IDX_W:0]   nxt_idx;

  always_comb begin
    nxt_st = st_ff;
    // two-flop synchronisers on the comparator, chip-select, sclk and switch pins
    nxt_st.over_s1 = over_cmp_in;
    nxt_st.over_s2 = st_ff.over_s1;
    nxt_st.over_d  = st_ff.over_s2;
    nxt_st.cs_s1   = cs_b_in;
    nxt_st.cs_s2   = st_ff.cs_s1;
    nxt_st.cs_d    = st_ff.cs_s2;
    nxt_st.ck_s1   = sclk_in;
    nxt_st.ck_s2   = st_ff.ck_s1;
    nxt_st.ck_d    = st_ff.ck_s2;
    nxt_st.sw_s1   = switch_input_pin_in;
    nxt_st.sw_s2   = st_ff.sw_s1;

    // comparator already holds the hysteresis, so only its levels matter
    over_enter = st_ff.over_s2 & ~st_ff.over_d;
    over_leave = ~st_ff.over_s2 & st_ff.over_d;
    cs_rise    = st_ff.cs_s2 & ~st_ff.cs_d;
    cs_fall    = ~st_ff.cs_s2 & st_ff.cs_d;
    ck_first   = st_ff.ck_s2 & ~st_ff.ck_d & ~st_ff.cs_s2 & ~st_ff.ck_seen;
    clr_stat   = cs_rise & st_ff.rd_seen;

    // ========================================================================
    // configuration, locked while monitoring runs
    if (cfg_load_in && !run_in) begin
      nxt_st.cfg = cfg_in;
    end

    // ========================================================================
    // polling
    mon_on  = run_in & ~st_ff.over_s2;
    tick    = 1'b0;
    cyc_end = 1'b0;
    nxt_idx = next_en(st_ff.cfg.en, st_ff.idx);
    if (!mon_on) begin
      // restart from the lowest enabled input; status is left untouched
      nxt_st.div = '0;
      nxt_st.idx = first_en(st_ff.cfg.en);
      nxt_st.chg = 1'b0;
    end else if (st_ff.div == `SICO_DIV_W'(POLL_CYC - 1)) begin
      nxt_st.div = '0;
      tick = 1'b1;
    end else begin
      nxt_st.div = st_ff.div + `SICO_DIV_W'(1);
    end
    if (tick) begin
      if (st_ff.cfg.en[st_ff.idx]) begin
        nxt_st.status[st_ff.idx] = st_ff.sw_s2[st_ff.idx];
        if (st_ff.status[st_ff.idx] != st_ff.sw_s2[st_ff.idx]) begin
          nxt_st.chg = 1'b1;
        end
      end
      if (nxt_idx[`SICO_IDX_W]) begin
        nxt_st.idx = nxt_idx[`SICO_IDX_W-1:0];
      end else begin
        cyc_end = 1'b1;
        nxt_st.idx = first_en(st_ff.cfg.en);
        nxt_st.chg = 1'b0;
        nxt_st.first = 1'b0;
      end
    end
    if (over_leave) begin
      nxt_st.first = 1'b1;
    end

    // ========================================================================
    // interrupt status; a new event beats a clear in the same cycle
    nxt_st.live = st_ff.over_s2;
    nxt_st.over_flag = (over_enter | over_leave) | (st_ff.over_flag & ~clr_stat);
    // the first cycle after recovery always reports, and is the new baseline
    nxt_st.chg_flag = (cyc_end & (st_ff.chg | nxt_st.status != st_ff.status | st_ff.first))
                      | (st_ff.chg_flag & ~clr_stat);
    nxt_st.irq_low = over_enter | over_leave | (cyc_end & (st_ff.chg | st_ff.first
                      | nxt_st.status != st_ff.status))
                      | (st_ff.irq_low & ~clr_stat);
    if (cs_fall || cs_rise) begin
      nxt_st.rd_seen = 1'b0;
    end else if (int_stat_read_in && !st_ff.cs_s2) begin
      nxt_st.rd_seen = 1'b1;
    end

    // frame flag is taken at the first clock edge of each frame
    if (cs_fall) begin
      nxt_st.ck_seen = 1'b0;
    end else if (ck_first) begin
      nxt_st.ck_seen = 1'b1;
      nxt_st.oth_flag = st_ff.live | st_ff.over_flag;
    end

    // ========================================================================
    // current steering and shared settings per input
    for (int i = 0; i < `SICO_N_IN; i++) begin
      if (i < `SICO_N_SINK) begin
        nxt_st.snk[i] = mon_on & st_ff.cfg.en[i] & st_ff.cfg.sink[i];
        nxt_st.src[i] = mon_on & st_ff.cfg.en[i] & ~st_ff.cfg.sink[i];
      end else begin
        nxt_st.snk[i] = 1'b0;
        nxt_st.src[i] = mon_on & st_ff.cfg.en[i];
      end
      nxt_st.thr_o[i*`SICO_THR_W +: `SICO_THR_W] =
        st_ff.cfg.thr[(i/4)*`SICO_THR_W +: `SICO_THR_W];
      nxt_st.wc_o[i*`SICO_WC_W +: `SICO_WC_W] =
        st_ff.cfg.wc[int'(wc_slot(i))*`SICO_WC_W +: `SICO_WC_W];
    end
  end

  // ==========================================================================
  // registers; reset empties the enable mask and selects sources
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      st_ff <= '0;
      st_ff.cfg.en <= `SICO_EN_RST;
      st_ff.cfg.sink <= `SICO_SINK_RST;
      st_ff.cfg.thr <= `SICO_THR_RST;
      st_ff.cfg.wc <= `SICO_WC_RST;
      st_ff.cs_s1 <= 1'b1;
      st_ff.cs_s2 <= 1'b1;
      st_ff.cs_d <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // outputs
  assign switch_status_out              = st_ff.status;
  assign overvoltage_live_status_out    = st_ff.live;
  assign overvoltage_event_flag_out     = st_ff.over_flag;
  assign switch_change_interrupt_out    = st_ff.chg_flag;
  assign other_interrupt_spi_flag_out   = st_ff.oth_flag;
  assign int_b_out                      = 1'b0 & st_ff.irq_low;
  assign int_oe_out                     = st_ff.irq_low;
  assign src_en_out                     = st_ff.src;
  assign sink_en_out                    = st_ff.snk;
  assign comparator_threshold_group_out = st_ff.thr_o;
  assign wetting_current_setting_out    = st_ff.wc_o;

  // ==========================================================================
  // checks
  currents_off_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    st_ff.over_s2 |=> (src_en_out == '0) && (sink_en_out == '0))
    else $error("currents on during over-voltage");
  entry_irq_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    over_enter |=> overvoltage_event_flag_out && int_oe_out)
    else $error("no interrupt on over-voltage entry");
  live_high_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    st_ff.over_s2 ##1 st_ff.over_s2 |-> overvoltage_live_status_out)
    else $error("live status low during over-voltage");
  frame_flag_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    ck_first && overvoltage_live_status_out |=> other_interrupt_spi_flag_out)
    else $error("frame flag missing during over-voltage");
  read_release_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    clr_stat && !over_enter && !over_leave && !cyc_end
      |=> !int_oe_out && !overvoltage_event_flag_out)
    else $error("interrupt not released after status read");
  hold_status_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    st_ff.over_s2 |=> $stable(switch_status_out))
    else $error("switch status changed during over-voltage");
  exit_irq_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    over_leave |=> overvoltage_event_flag_out && int_oe_out
      && !overvoltage_live_status_out)
    else $error("no interrupt on over-voltage exit");
  restart_index_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    !mon_on |=> st_ff.idx == first_en($past(st_ff.cfg.en)))
    else $error("polling does not restart at lowest enabled input");
  source_only_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    sink_en_out[`SICO_N_IN-1:`SICO_N_SINK] == '0)
    else $error("sink enabled on a source-only input");
  disabled_off_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    ((src_en_out | sink_en_out) & ~st_ff.cfg.en) == '0)
    else $error("current on a disabled input");
  enable_reset_a: assert property (@(posedge core_clk_in)
    !rst_b_in |=> st_ff.cfg.en == '0 && st_ff.cfg.sink == '0)
    else $error("enable mask not cleared by reset");
  cfg_locked_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    run_in |=> $stable(st_ff.cfg))
    else $error("configuration changed while running");

  // ==========================================================================
  // checks on sharing, steering and recovery
  // only the end groups are spot-checked; every input goes through the same loop
  thr_group_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    comparator_threshold_group_out[4*`SICO_THR_W-1:0]
      == {4{$past(st_ff.cfg.thr[`SICO_THR_W-1:0])}})
    else $error("first threshold group not shared by four inputs");
  thr_last_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    comparator_threshold_group_out[`SICO_N_IN*`SICO_THR_W-1:(`SICO_N_IN-4)*`SICO_THR_W]
      == {4{$past(st_ff.cfg.thr[`SICO_N_THR*`SICO_THR_W-1:(`SICO_N_THR-1)*`SICO_THR_W])}})
    else $error("last threshold group not shared by four inputs");
  wc_pair_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    wetting_current_setting_out[2*`SICO_WC_W-1:0]
      == {2{$past(st_ff.cfg.wc[`SICO_WC_W-1:0])}})
    else $error("first wetting current pair not shared");
  wc_single_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    wetting_current_setting_out[`SICO_N_IN*`SICO_WC_W-1:(`SICO_N_IN-1)*`SICO_WC_W]
      == $past(st_ff.cfg.wc[`SICO_N_WC*`SICO_WC_W-1:(`SICO_N_WC-1)*`SICO_WC_W]))
    else $error("last input does not own its wetting current");
  sink_select_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    mon_on |=> sink_en_out[`SICO_N_SINK-1:0]
      == ($past(st_ff.cfg.en[`SICO_N_SINK-1:0]) & $past(st_ff.cfg.sink)))
    else $error("sink enables do not follow the select bits");
  run_steer_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    mon_on |=> (src_en_out | sink_en_out) == $past(st_ff.cfg.en))
    else $error("enabled inputs not driven while running");
  reset_source_a: assert property (@(posedge core_clk_in)
    !rst_b_in |=> sink_en_out == '0)
    else $error("sinks active after reset");
  sample_input_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    tick && st_ff.cfg.en[st_ff.idx]
      |=> switch_status_out[$past(st_ff.idx)] == $past(st_ff.sw_s2[st_ff.idx]))
    else $error("polled input status not stored");
  first_cycle_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    cyc_end && st_ff.first |=> switch_change_interrupt_out && int_oe_out)
    else $error("no change interrupt after first cycle of recovery");
  no_repeat_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    clr_stat && st_ff.over_s2 && st_ff.over_d
      |=> !overvoltage_event_flag_out && !int_oe_out)
    else $error("over-voltage interrupt repeated while level stays");
  hold_irq_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    cs_rise && !st_ff.rd_seen && int_oe_out |=> int_oe_out)
    else $error("interrupt released without a status read");
  sync_depth_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    over_enter |-> $past(over_cmp_in, 2) && !$past(over_cmp_in, 3))
    else $error("over-voltage entry not taken from the synchronised pin");

endmodule

// ===== hw/sico_defs.svh
// Purpose: constants of the switch input configuration and supply fault block
// Assumes: 100 MHz core clock
// Notes:   offsets do not exist here; the block has plain configuration ports
`ifndef SICO_DEFS_SVH
`define SICO_DEFS_SVH

// ==========================================================================
// sizes
`define SICO_N_IN          24
`define SICO_N_SINK        10
`define SICO_N_THR         6
`define SICO_THR_W         2
`define SICO_N_WC          15
`define SICO_WC_W          3
`define SICO_IDX_W         5
`define SICO_DIV_W         16

// ==========================================================================
// reset values
`define SICO_EN_RST        24'h000000
`define SICO_SINK_RST      10'h000
`define SICO_THR_RST       12'h000
`define SICO_WC_RST        45'h000000000000

// ==========================================================================
// timing
`define SICO_CLK_NS        10
`define SICO_POLL_STEP_NS  1000
`define SICO_POLL_STEP_CYC ((`SICO_POLL_STEP_NS + `SICO_CLK_NS - 1) / `SICO_CLK_NS)

`endif

// ===== hw/sico_pkg.sv
// Purpose: types of the switch input configuration and supply fault block
// Assumes: sico_defs.svh gives the sizes
// Notes:   all state of the top sits in one packed struct
`include "sico_defs.svh"

package sico_pkg;

  // ========================================================================
  // input configuration as loaded from the host side
  typedef struct packed {
    logic [`SICO_N_IN-1:0]              en;
    logic [`SICO_N_SINK-1:0]            sink;
    logic [`SICO_N_THR*`SICO_THR_W-1:0] thr;
    logic [`SICO_N_WC*`SICO_WC_W-1:0]   wc;
  } sico_cfg_type;

  // ========================================================================
  // whole module state
  typedef struct packed {
    logic                               over_s1;
    logic                               over_s2;
    logic                               over_d;
    logic                               cs_s1;
    logic                               cs_s2;
    logic                               cs_d;
    logic                               ck_s1;
    logic                               ck_s2;
    logic                               ck_d;
    logic [`SICO_N_IN-1:0]              sw_s1;
    logic [`SICO_N_IN-1:0]              sw_s2;
    logic                               ck_seen;
    logic                               rd_seen;
    sico_cfg_type                       cfg;
    logic                               live;
    logic                               over_flag;
    logic                               chg_flag;
    logic                               irq_low;
    logic                               oth_flag;
    logic [`SICO_IDX_W-1:0]             idx;
    logic [`SICO_DIV_W-1:0]             div;
    logic [`SICO_N_IN-1:0]              status;
    logic                               chg;
    logic                               first;
    logic [`SICO_N_IN-1:0]              src;
    logic [`SICO_N_IN-1:0]              snk;
    logic [`SICO_N_IN*`SICO_THR_W-1:0]  thr_o;
    logic [`SICO_N_IN*`SICO_WC_W-1:0]   wc_o;
  } sico_state_type;

endpackage

// ===== dv/sico_host.sv
// Purpose: microcontroller side model, SPI host framing transfers
// Assumes: sclk period 160 ns, sixteen core cycles
// Notes:   sclk stands low outside frames, as a real host leaves it
module sico_host (
  input  wire logic core_clk_in,
  output logic      cs_b_out,
  output logic      sclk_out,
  output logic      stat_rd_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // idle levels
  initial begin
    cs_b_out    = 1'h1;
    sclk_out    = 1'h0;
    stat_rd_out = 1'h0;
  end

  // ==========================================================================
  // one frame of eight sclk periods; rd says interrupt status is read in it
  task automatic frame(input logic rd);
    @(posedge core_clk_in);
    cs_b_out <= 1'h0;
    repeat (8) @(posedge core_clk_in);
    for (int i = 0; i < 16; i++) begin
      repeat (8) @(posedge core_clk_in);
      sclk_out <= ~sclk_out;
      if (i == 4) stat_rd_out <= rd;
      if (i == 6) stat_rd_out <= 1'h0;
    end
    // chip select rises last, after the status read is over
    repeat (8) @(posedge core_clk_in);
    cs_b_out <= 1'h1;
  endtask
endmodule

// ===== dv/sico_top_tb.sv
// Purpose: self-checking bench of input configuration and over-voltage handling
// Assumes: polling step shortened to 4 cycles
// Notes:   flags vector is {live, event, change, pin pulled}
module sico_top_tb;
  import sico_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // signals
  localparam int POLL = 4;
  logic         clk = 1'h0;
  logic         rst_b;
  logic         over;
  logic         run;
  logic         ld;
  sico_cfg_type cfg;
  sico_cfg_type cfg_a;
  sico_cfg_type cfg_b;
  logic [23:0]  pins;
  logic [23:0]  sts, src, snk;
  logic [47:0]  thr_o;
  logic [71:0]  wc_o;
  logic         live, ev, chg, oth, oe, cs_b, sclk, rd, int_b;
  logic [3:0]   fl;
  int           n_mismatch = 0;
  int           tests_run = 0;
  int           slot [24] = '{0, 0, 1, 1, 2, 3, 4, 4, 5, 5, 6, 7, 8, 8, 9, 9,
                              10, 10, 11, 11, 12, 12, 13, 14};
  assign fl = {live, ev, chg, oe};

  always #5 clk = ~clk;

  sico_host host (.core_clk_in(clk), .cs_b_out(cs_b), .sclk_out(sclk), .stat_rd_out(rd));

  sico_top #(.POLL_CYC(POLL)) DUT (
    .core_clk_in(clk), .rst_b_in(rst_b), .over_cmp_in(over), .cs_b_in(cs_b),
    .sclk_in(sclk), .int_stat_read_in(rd), .run_in(run), .cfg_load_in(ld),
    .cfg_in(cfg), .switch_input_pin_in(pins), .switch_status_out(sts),
    .overvoltage_live_status_out(live), .overvoltage_event_flag_out(ev),
    .switch_change_interrupt_out(chg), .other_interrupt_spi_flag_out(oth),
    .int_b_out(int_b), .int_oe_out(oe), .src_en_out(src), .sink_en_out(snk),
    .comparator_threshold_group_out(thr_o), .wetting_current_setting_out(wc_o));

  // ==========================================================================
  // helpers
  task automatic chk_v(input logic [119:0] got, input logic [119:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  function automatic logic [119:0] emap(input sico_cfg_type c);
    logic [119:0] m;
    for (int i = 0; i < 24; i++) begin
      m[2*i+:2]      = c.thr[2*(i/4)+:2];
      m[48+3*i+:3]   = c.wc[3*slot[i]+:3];
    end
    return m;
  endfunction

  task automatic load(input sico_cfg_type c);
    @(posedge clk);
    cfg <= c;
    ld  <= 1'h1;
    @(posedge clk);
    ld  <= 1'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wait_chg;
    for (int i = 0; i < 400 && chg !== 1'h1; i++) @(posedge clk);
    @(negedge clk);
    chk_v(chg, 1'h1);
  endtask

  task automatic go(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========================================================================
  // watchdog: the sequence needs about 18 us
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end

  // ==========================================================================
  // tests
  initial begin
    rst_b <= 1'h0;
    over  <= 1'h0;
    run   <= 1'h0;
    ld    <= 1'h0;
    cfg   <= '0;
    pins  <= 24'h000000;
    cfg_a.en   = 24'hFFFFFE;
    cfg_a.sink = 10'h2A5;
    cfg_a.thr  = 12'h9C9;
    for (int s = 0; s < 15; s++) cfg_a.wc[3*s+:3] = 3'(s + 1);
    cfg_b = ~cfg_a;
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    run   <= 1'h1;
    go(4);
    chk_v(src, 24'h000000);
    chk_v(snk, 24'h000000);
    chk_v(fl, 4'h0);
    @(posedge clk);
    run <= 1'h0;
    load(cfg_a);
    chk_v({wc_o, thr_o}, emap(cfg_a));
    @(posedge clk);
    run <= 1'h1;
    go(2);
    chk_v(src, cfg_a.en & ~{14'h0000, cfg_a.sink});
    chk_v(snk, cfg_a.en & {14'h0000, cfg_a.sink});
    load(cfg_b);
    chk_v({wc_o, thr_o}, emap(cfg_a));
    chk_v(src, cfg_a.en & ~{14'h0000, cfg_a.sink});
    @(posedge clk);
    pins <= 24'hA5C33D;
    wait_chg();
    // the cycle that saw the pins move had already polled its lowest inputs
    go(24 * POLL);
    chk_v(sts, 24'hA5C33C);
    chk_v(oe, 1'h1);
    chk_v(int_b, 1'h0);
    host.frame(1'h0);
    go(8);
    chk_v(fl, 4'h3);
    host.frame(1'h1);
    go(8);
    chk_v(fl, 4'h0);
    // over-voltage entry; answer within five edges of the pin change
    @(posedge clk);
    over <= 1'h1;
    go(5);
    chk_v(fl, 4'hD);
    chk_v({src, snk}, 48'h0);
    @(posedge clk);
    pins <= 24'h5A3CC2;
    go(200);
    chk_v(sts, 24'hA5C33C);
    host.frame(1'h0);
    go(8);
    chk_v(oth, 1'h1);
    chk_v(fl, 4'hD);
    host.frame(1'h1);
    go(8);
    chk_v(fl, 4'h8);
    go(100);
    chk_v(fl, 4'h8);
    // exit restarts polling with the settings kept from before
    @(posedge clk);
    over <= 1'h0;
    go(5);
    chk_v(fl, 4'h5);
    chk_v(src, cfg_a.en & ~{14'h0000, cfg_a.sink});
    wait_chg();
    chk_v(sts, 24'h5A3CC2);
    host.frame(1'h1);
    go(8);
    chk_v(fl, 4'h0);
    go(300);
    chk_v(fl, 4'h0);
    host.frame(1'h0);
    go(8);
    chk_v(oth, 1'h0);
    @(posedge clk);
    run <= 1'h0;
    load(cfg_b);
    chk_v({wc_o, thr_o}, emap(cfg_b));
    end_of_test();
  end
endmodule
